// ==== next_page_transmit_register.sv ====
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

module next_page_transmit_register
  import page_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // management register port
  input  wire mgmt_req_t         mgmt,
  output logic [DATA_W-1:0]      rdata,
  // arbitration side, same clock domain
  input  wire logic              page_tx_start,
  input  wire logic              page_exchanged,
  input  wire logic              exchanged_toggle,
  // page contents toward the link code word
  output page_word_t             tx_word,
  output logic                   more_pages_request,
  output logic                   message_page_select,
  output logic                   comply_acknowledge
);

  typedef struct packed {
    logic              more_pages_request;
    logic              message_page_select;
    logic              comply_acknowledge;
    logic [CODE_W-1:0] code;
    logic [DATA_W-1:0] rdata;
  } ctrl_state_t;

  ctrl_state_t state;
  ctrl_state_t next_state;
  page_word_t  image;
  logic        toggle;
  logic        hit;

  ////////////////////////////////////////////////////////////////////////////
  assign hit = (mgmt.addr == NPT_OFFSET);

  always_comb
  begin
    image                     = '0;
    image.more_pages_request  = state.more_pages_request;
    image.reserved            = RSVD_VALUE;
    image.message_page_select = state.message_page_select;
    image.comply_acknowledge  = state.comply_acknowledge;
    image.toggle              = toggle;
    image.code                = state.code;
  end

  always_comb
  begin
    page_word_t wr_word;
    wr_word    = page_word_t'(mgmt.wdata);
    next_state = state;
    // answer stands for one cycle only, then returns to zero
    next_state.rdata = ZERO_WORD;
    if (mgmt.rd && hit)
    begin
      next_state.rdata = image;
    end
    else if (mgmt.rd)
    begin
      next_state.rdata = ZERO_WORD;
    end
    // reserved and toggle bits of the write data are dropped
    if (mgmt.wr && hit)
    begin
      next_state.more_pages_request  = wr_word.more_pages_request;
      next_state.message_page_select = wr_word.message_page_select;
      next_state.comply_acknowledge  = wr_word.comply_acknowledge;
      next_state.code                = wr_word.code;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state.more_pages_request  <= REQ_RESET;
      state.message_page_select <= SEL_RESET;
      state.comply_acknowledge  <= ACK_RESET;
      state.code                <= CODE_NULL;
      state.rdata               <= ZERO_WORD;
    end
    else
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // toggle tracking and the snapshot of the word on the line
  page_word_latch u_latch (
    .sys_clk          (sys_clk),
    .arst_n           (arst_n),
    .page_image       (image),
    .tx_start         (page_tx_start),
    .exchanged        (page_exchanged),
    .exchanged_toggle (exchanged_toggle),
    .tx_word          (tx_word),
    .toggle           (toggle)
  );

  assign rdata               = state.rdata;
  assign more_pages_request  = state.more_pages_request;
  assign message_page_select = state.message_page_select;
  assign comply_acknowledge  = state.comply_acknowledge;

  ////////////////////////////////////////////////////////////////////////////
  // helper: no write has reached the register since reset
  logic untouched;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      untouched <= 1'b1;
    end
    else if (mgmt.wr && hit)
    begin
      untouched <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  property p_read_image;
    mgmt.rd && mgmt.addr == NPT_OFFSET |=> rdata == $past(image);
  endproperty
  a_read_image: assert property (p_read_image)
    else $error("read of the register did not return its image");

  property p_read_other;
    (mgmt.rd && mgmt.addr != NPT_OFFSET) || !mgmt.rd |=> rdata == ZERO_WORD;
  endproperty
  a_read_other: assert property (p_read_other)
    else $error("read data not zero outside a register read");

  property p_req_write;
    mgmt.wr && mgmt.addr == NPT_OFFSET ##1 mgmt.rd && mgmt.addr == NPT_OFFSET
      |=> rdata[DATA_W-1] == $past(mgmt.wdata[DATA_W-1], 2);
  endproperty
  a_req_write: assert property (p_req_write)
    else $error("request flag did not read back as written");

  property p_reserved_zero;
    mgmt.wr && mgmt.wdata[DATA_W-2] ##1 mgmt.rd && mgmt.addr == NPT_OFFSET
      |=> rdata[DATA_W-2] == RSVD_VALUE;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit read back non-zero");

  property p_sel_write;
    mgmt.wr && mgmt.addr == NPT_OFFSET
      |=> message_page_select == $past(mgmt.wdata[DATA_W-3]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("page type selector not updated by write");

  property p_sel_reset;
    untouched |-> message_page_select == SEL_RESET && more_pages_request == REQ_RESET;
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("selector or request flag lost reset value");

  property p_ack_write;
    mgmt.wr && mgmt.addr == NPT_OFFSET
      |=> comply_acknowledge == $past(mgmt.wdata[DATA_W-4]);
  endproperty
  a_ack_write: assert property (p_ack_write)
    else $error("acknowledge flag not updated by write");

  property p_ack_hold;
    !(mgmt.wr && mgmt.addr == NPT_OFFSET) |=> $stable(comply_acknowledge)
      && $stable(message_page_select) && $stable(more_pages_request);
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("software field changed without a write");

  property p_toggle_ro;
    mgmt.wr && mgmt.addr == NPT_OFFSET && !page_exchanged |=> $stable(toggle);
  endproperty
  a_toggle_ro: assert property (p_toggle_ro)
    else $error("software write altered the toggle");

  property p_code_null;
    untouched && mgmt.rd && mgmt.addr == NPT_OFFSET
      |=> rdata[CODE_W-1:0] == CODE_NULL;
  endproperty
  a_code_null: assert property (p_code_null)
    else $error("code field did not read the null page after reset");

  property p_tx_copy;
    page_tx_start |=> tx_word.message_page_select == $past(message_page_select)
      && tx_word.comply_acknowledge == $past(comply_acknowledge);
  endproperty
  a_tx_copy: assert property (p_tx_copy)
    else $error("outgoing word lacks register contents");

  property p_code_write;
    mgmt.wr && hit ##1 mgmt.rd && hit
      |=> rdata[CODE_W-1:0] == $past(mgmt.wdata[CODE_W-1:0], 2);
  endproperty
  a_code_write: assert property (p_code_write)
    else $error("code field did not read back as written");

  property p_toggle_read;
    mgmt.rd && hit |=> rdata[CODE_W] == $past(toggle);
  endproperty
  a_toggle_read: assert property (p_toggle_read)
    else $error("read data toggle bit differs from tracked toggle");

  property p_tx_reserved;
    page_tx_start |=> tx_word.reserved == RSVD_VALUE;
  endproperty
  a_tx_reserved: assert property (p_tx_reserved)
    else $error("outgoing word carries a set reserved bit");

  c_write_read: cover property (mgmt.wr && hit ##1 mgmt.rd && hit);
  c_send_page:  cover property (mgmt.wr && hit ##[1:8] page_tx_start ##[1:8] page_exchanged);
  c_unmapped:   cover property (mgmt.rd && !hit);
  c_null_read:  cover property (untouched && mgmt.rd && hit);

endmodule

// ==== next_page_transmit_register_test.sv ====
`timescale 1ns/1ps

module next_page_transmit_register_test;
  import page_pkg::*;

  logic              sys_clk          = 1'b0;
  logic              arst_n           = 1'b0;
  mgmt_req_t         mgmt             = '0;
  logic              page_tx_start    = 1'b0;
  logic              page_exchanged   = 1'b0;
  logic              exchanged_toggle = 1'b0;
  logic [DATA_W-1:0] rdata;
  page_word_t        tx_word;
  logic              more_pages_request;
  logic              message_page_select;
  logic              comply_acknowledge;
  int                failures         = 0;
  int                cmp_count        = 0;
  // model state, starting at the reset image
  int                m_req            = 0;
  int                m_sel            = 1;
  int                m_ack            = 0;
  int                m_tog            = 0;
  int                m_code           = 1;
  int                m_tx             = 0;
  int                m_rd             = 0;

  next_page_transmit_register dut (
    .sys_clk             (sys_clk),
    .arst_n              (arst_n),
    .mgmt                (mgmt),
    .rdata               (rdata),
    .page_tx_start       (page_tx_start),
    .page_exchanged      (page_exchanged),
    .exchanged_toggle    (exchanged_toggle),
    .tx_word             (tx_word),
    .more_pages_request  (more_pages_request),
    .message_page_select (message_page_select),
    .comply_acknowledge  (comply_acknowledge)
  );

  always #2 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////

  function automatic int image();
    return (m_req << 15) | (m_sel << 13) | (m_ack << 12) | (m_tog << 11) | m_code;
  endfunction

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // model: everything is worked out from the pre-edge image, so a write or an
  // exchange in the same cycle as a snapshot does not leak into it

  always @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
    begin
      m_req  = 0;
      m_sel  = 1;
      m_ack  = 0;
      m_tog  = 0;
      m_code = 1;
      m_tx   = 0;
      m_rd   = 0;
    end
    else
    begin
      m_rd = (mgmt.rd && mgmt.addr == NPT_OFFSET) ? image() : 0;
      if (page_tx_start)
        m_tx = image();
      if (page_exchanged)
        m_tog = exchanged_toggle ? 0 : 1;
      if (mgmt.wr && mgmt.addr == NPT_OFFSET)
      begin
        m_req  = int'(mgmt.wdata[15]);
        m_sel  = int'(mgmt.wdata[13]);
        m_ack  = int'(mgmt.wdata[12]);
        m_code = int'(mgmt.wdata[10:0]);
      end
      #1;
      cmp_word(rdata, m_rd[15:0], "rdata");
      cmp_word(tx_word, m_tx[15:0], "tx_word");
      cmp_bit(more_pages_request, m_req[0], "more_pages_request");
      cmp_bit(message_page_select, m_sel[0], "message_page_select");
      cmp_bit(comply_acknowledge, m_ack[0], "comply_acknowledge");
    end

  ////////////////////////////////////////////////////////////////////////////////

  task automatic step(input bit w, input bit r, input logic [4:0] a, input logic [15:0] d,
                      input bit s, input bit e, input bit t);
    mgmt             <= '{addr: a, wdata: d, wr: w, rd: r};
    page_tx_start    <= s;
    page_exchanged   <= e;
    exchanged_toggle <= t;
    @(posedge sys_clk);
  endtask

  task automatic random_run(input int n);
    int k;
    logic [4:0] a;
    repeat (n)
    begin
      k = int'($urandom % 4);
      // mostly the mapped offset so that the fields keep changing
      a = ($urandom % 3 == 0) ? 5'($urandom) : NPT_OFFSET;
      step(k == 0, k == 1, a, 16'($urandom), $urandom % 3 == 0, $urandom % 3 == 0, 1'($urandom));
    end
  endtask

  initial
  begin
    void'($urandom(47304));
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    step(0, 1, NPT_OFFSET, 16'h0000, 0, 0, 0);
    // write all ones together with a snapshot, then read back at once
    step(1, 0, NPT_OFFSET, 16'hffff, 1, 0, 0);
    step(0, 1, NPT_OFFSET, 16'h0000, 1, 0, 0);
    step(0, 0, 5'h00, 16'h0000, 0, 1, 0);
    step(0, 0, 5'h00, 16'h0000, 1, 1, 1);
    step(1, 0, NPT_OFFSET, 16'h4801, 1, 0, 0);
    step(0, 1, NPT_OFFSET, 16'h0000, 0, 0, 0);
    step(1, 0, 5'h06, 16'h0000, 0, 0, 0);
    step(0, 1, 5'h06, 16'h0000, 0, 0, 0);
    step(0, 1, 5'h08, 16'h0000, 0, 0, 0);
    random_run(600);
    // quiet the inputs so no request is still pending when reset lets go
    step(0, 0, 5'h00, 16'h0000, 0, 0, 0);
    // reset lands off the edge so the model sees it before its next compare
    #2 arst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    step(0, 1, NPT_OFFSET, 16'h0000, 0, 0, 0);
    random_run(300);
    conclude();
  end

  initial
  begin
    #(4 * 2000);
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end

endmodule

// ==== np_pkg.sv ====
// Overview of operation
// - The register holds the page sent to the link partner, at management address 0x07.
// - Bit 15 is a read/write request for another next page, reset to zero.
// - Bit 14 is reserved: writes to it are ignored and it always reads as zero.
// - Bit 12 is a read/write flag, reset to zero, set when the device will comply.
// - Bit 11 is a read-only toggle, reset to zero, the inverse of the last exchanged toggle.
// - Bits 10 to 0 are a read/write code field that resets to 000 0000 0001, the null page.
package page_pkg;

  localparam int unsigned MGMT_ADDR_W = 5;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned CODE_W      = 11;

  localparam logic [MGMT_ADDR_W-1:0] NPT_OFFSET = 5'h07;

  // reset values of the fields
  localparam logic              REQ_RESET    = 1'b0;
  localparam logic              SEL_RESET    = 1'b1;
  localparam logic              ACK_RESET    = 1'b0;
  localparam logic              TOGGLE_RESET = 1'b0;
  localparam logic              RSVD_VALUE   = 1'b0;
  localparam logic [CODE_W-1:0] CODE_NULL    = 11'h001;
  localparam logic [DATA_W-1:0] ZERO_WORD    = 16'h0000;

  // register image, bit 15 down to bit 0
  typedef struct packed {
    logic              more_pages_request;
    logic              reserved;
    logic              message_page_select;
    logic              comply_acknowledge;
    logic              toggle;
    logic [CODE_W-1:0] code;
  } page_word_t;

  // management port request, one cycle per strobe
  typedef struct packed {
    logic [MGMT_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]      wdata;
    logic                   wr;
    logic                   rd;
  } mgmt_req_t;

endpackage

// ==== np_word_latch.sv ====
`timescale 1ns/1ps

module page_word_latch
  import page_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // software-owned fields, toggle slot ignored
  input  wire page_word_t page_image,
  // arbitration events
  input  wire logic       tx_start,
  input  wire logic       exchanged,
  input  wire logic       exchanged_toggle,
  // results
  output page_word_t      tx_word,
  output logic            toggle
);

  typedef struct packed {
    page_word_t word;
    logic       toggle;
  } latch_state_t;

  latch_state_t state;
  latch_state_t next_state;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    // snapshot so software edits mid-page never corrupt the word on the line
    if (tx_start)
    begin
      next_state.word          = page_image;
      next_state.word.reserved = RSVD_VALUE;
      next_state.word.toggle   = state.toggle;
    end
    if (exchanged)
    begin
      next_state.toggle = ~exchanged_toggle;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state             <= '0;
      state.word.toggle <= TOGGLE_RESET;
      state.toggle      <= TOGGLE_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign tx_word = state.word;
  assign toggle  = state.toggle;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  property p_toggle_follows;
    exchanged |=> toggle == !$past(exchanged_toggle);
  endproperty
  a_toggle_follows: assert property (p_toggle_follows)
    else $error("toggle not inverse of exchanged toggle");

  property p_toggle_holds;
    !exchanged |=> $stable(toggle);
  endproperty
  a_toggle_holds: assert property (p_toggle_holds)
    else $error("toggle changed without an exchange");

  property p_word_copy;
    tx_start |=> tx_word.code == $past(page_image.code)
      && tx_word.more_pages_request == $past(page_image.more_pages_request)
      && tx_word.toggle == $past(toggle);
  endproperty
  a_word_copy: assert property (p_word_copy)
    else $error("outgoing word not copied at transmission start");

  property p_word_stable;
    !tx_start |=> $stable(tx_word);
  endproperty
  a_word_stable: assert property (p_word_stable)
    else $error("outgoing word changed outside a transmission start");

  c_exchange: cover property (exchanged ##1 tx_start);

endmodule
